// *** nic_power_state_reset_ctrl.sv ***
/*
 * Power-state, reset and bus-isolation controller of the network controller.
 * Assumes clk is the PCI clock domain, config accesses arrive as one-cycle
 * strobes from the PCI target logic, and all input pins named *Pin or *_n are async.
 */
`timescale 1ns/10ps
module nic_power_state_reset_ctrl
    import nic_pm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic powerOnResetIn_n,
    input wire logic busIsolateIn_n,
    input wire logic pciResetIn_n,
    input wire logic auxPowerSensePin,
    input wire logic linkValidPin,
    input wire logic interestingPacket,
    input wire logic lowPowerAllow,
    input wire logic barWrite,
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [7:0] cfgAddr,
    input wire logic [15:0] cfgWdata,
    output logic [15:0] cfgRdata,
    output logic cfgRdValid,
    output logic internalInit,
    output logic busPowerUp,
    output logic pciOe_n,
    output logic pmeOut,
    output logic pmeOe_n,
    output logic auxPowerPresent,
    output logic [2:0] powerState,
    output logic targetOnly,
    output logic configOnly,
    output logic fullFunction,
    output logic linkLowPower,
    output logic linkTxEnable,
    output logic wakeArmed
);

    // ------------------------------------------------------------
    // Input synchronization
    // ------------------------------------------------------------
    logic [4:0] syncVec;
    logic porSync_n;
    logic isoSync_n;
    logic pciRstSync_n;
    logic auxSync;
    logic linkSync;

    pin_sync #(
        .WIDTH(5),
        .RESET_VALUE(5'h07)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn({linkValidPin, auxPowerSensePin, pciResetIn_n, busIsolateIn_n, powerOnResetIn_n}), // [R22]
        .syncOut(syncVec)
    );

    assign porSync_n = syncVec[0];
    assign isoSync_n = syncVec[1];
    assign pciRstSync_n = syncVec[2];
    assign auxSync = syncVec[3];
    assign linkSync = syncVec[4];

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    function automatic logic isSleepState(input pwr_state_t s);
        isSleepState = (s == PS_D2) || (s == PS_D3);
    endfunction

    function automatic logic isLowD(input pwr_state_t s);
        isLowD = (s == PS_D1) || (s == PS_D2) || (s == PS_D3);
    endfunction

    logic porActive;
    logic isolated;
    logic pciRstSeen;
    logic pciRstEff;
    logic pciRstLow_q;
    logic isolated_q;
    logic rstTrail;
    logic isoTrail;
    logic levelInit;
    logic edgeInit;
    logic initNow;
    logic keepPmContext;
    logic link_q;
    logic auxSample_q;
    logic d0Active_q;
    logic [1:0] dField_q;
    logic pmeEn_q;
    logic pmeStatus_q;
    pwr_state_t state;
    logic pciQuiet;
    logic cfgAllowed;
    logic lowPower;
    logic wakeEvent;
    logic wakeCapable;
    logic pmcsrWrite;

    assign porActive = !porSync_n; // [R11]
    assign isolated = !isoSync_n;
    // Isolation hides RST# completely
    assign pciRstSeen = !pciRstSync_n && !isolated; // [R12]
    // Aux power makes RST# inert for every circuit but the aux strap sampler
    assign pciRstEff = pciRstSeen && !auxSample_q; // [R15]
    // Raw RST# edge: isolation entry masks the level but is no trailing edge
    assign rstTrail = pciRstLow_q && pciRstSync_n && !isolated && !auxSample_q; // [R18]
    assign isoTrail = isolated_q && !isolated; // [R19]

    // ------------------------------------------------------------
    // D-state from software field and D0 substate
    // ------------------------------------------------------------
    always_comb begin
        case (dField_q) // [R23]
            DSTATE_D1: state = PS_D1;
            DSTATE_D2: state = PS_D2;
            DSTATE_D3: state = PS_D3;
            default: state = d0Active_q ? PS_D0A : PS_D0U;
        endcase
    end

    // ------------------------------------------------------------
    // Initialization sources
    // ------------------------------------------------------------
    assign levelInit = pciRstEff && (state != PS_D3); // [R16]
    assign edgeInit = (rstTrail && (state == PS_D3)) || isoTrail; // [R17] [R19]
    assign initNow = porActive || levelInit || edgeInit;
    // D3 RST# edge init keeps wake context, RST# level init keeps it when wake is enabled; POR and isolate edges never do
    assign keepPmContext = !porActive && !isoTrail && (pmeEn_q || (state == PS_D3)); // [R13] [R17]

    always_ff @(posedge clk) begin
        if (rst) begin
            pciRstLow_q <= 1'b0;
            isolated_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            // Unmasked level, so isolation cannot fake a release
            pciRstLow_q <= !pciRstSync_n;
            isolated_q <= isolated;
            link_q <= linkSync;
        end
    end

    // ------------------------------------------------------------
    // Aux power strap
    // ------------------------------------------------------------
    // Only sampled while a reset is active, so a wandering flash line is harmless
    always_ff @(posedge clk) begin
        if (rst) begin
            auxSample_q <= 1'b0;
        end else if (porActive || pciRstSeen) begin
            auxSample_q <= auxSync; // [R10]
        end
    end

    // ------------------------------------------------------------
    // PCI access gating
    // ------------------------------------------------------------
    assign pciQuiet = isolated || pciRstEff || porActive; // [R12] [R14]
    assign cfgAllowed = !pciQuiet;
    assign pmcsrWrite = cfgAllowed && cfgWrite && (cfgAddr == POWER_CTRL_STATUS_REGISTER_OFFSET);

    // ------------------------------------------------------------
    // D0 substate
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            d0Active_q <= 1'b0;
        end else if (initNow) begin
            d0Active_q <= 1'b0; // [R20]
        end else if (cfgAllowed && barWrite && dField_q == DSTATE_D0) begin
            d0Active_q <= 1'b1; // [R20]
        end
    end

    // ------------------------------------------------------------
    // Power control/status register
    // ------------------------------------------------------------
    // Power state field survives init whenever wake context is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            dField_q <= POWER_CTRL_STATUS_REGISTER_RESET[PS_LSB +: 2];
        end else if (initNow && !keepPmContext) begin
            dField_q <= POWER_CTRL_STATUS_REGISTER_RESET[PS_LSB +: 2];
        end else if (pmcsrWrite) begin
            dField_q <= cfgWdata[PS_LSB +: 2]; // [R23]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pmeEn_q <= POWER_CTRL_STATUS_REGISTER_RESET[PME_EN_BIT];
        end else if (initNow && !keepPmContext) begin
            pmeEn_q <= POWER_CTRL_STATUS_REGISTER_RESET[PME_EN_BIT];
        end else if (pmcsrWrite) begin
            pmeEn_q <= cfgWdata[PME_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Wake events
    // ------------------------------------------------------------
    always_comb begin
        wakeEvent = 1'b0;
        case (state)
            PS_D0U: wakeEvent = 1'b0; // [R7]
            PS_D0A: wakeEvent = linkSync != link_q; // [R8]
            default: begin
                if (link_q) begin
                    wakeEvent = (interestingPacket && !lowPower) || !linkSync; // [R9] [R4]
                end else begin
                    wakeEvent = linkSync; // [R9] [R1]
                end
            end
        endcase
    end

    // Wake needs the enable bit; isolation does not stop it on aux power
    assign wakeCapable = pmeEn_q; // [R21] [R5] [R6]
    assign lowPower = isSleepState(state) && !link_q && lowPowerAllow; // [R1] [R3] [R4]

    // Status is sticky; a new event wins over a write-one-to-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            pmeStatus_q <= POWER_CTRL_STATUS_REGISTER_RESET[PME_STATUS_BIT];
        end else if (initNow && !keepPmContext) begin
            pmeStatus_q <= POWER_CTRL_STATUS_REGISTER_RESET[PME_STATUS_BIT];
        end else if (wakeEvent && wakeCapable) begin
            pmeStatus_q <= 1'b1; // [R21]
        end else if (pmcsrWrite && cfgWdata[PME_STATUS_BIT]) begin
            pmeStatus_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Level inits hold it; edge inits give one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            internalInit <= 1'b1;
        end else begin
            internalInit <= initNow;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busPowerUp <= 1'b0;
        end else begin
            busPowerUp <= rstTrail; // [R18]
        end
    end

    // Floated while power-on reset, isolation or RST# without aux power is in force
    always_ff @(posedge clk) begin
        if (rst) begin
            pciOe_n <= 1'b1;
        end else begin
            pciOe_n <= pciQuiet; // [R12] [R14]
        end
    end

    // ------------------------------------------------------------
    // Wake pin
    // ------------------------------------------------------------
    // Wake pin is open drain and stays live through isolation
    always_ff @(posedge clk) begin
        if (rst) begin
            pmeOut <= 1'b0;
            pmeOe_n <= 1'b1;
        end else begin
            pmeOut <= 1'b0;
            pmeOe_n <= !(pmeStatus_q && pmeEn_q); // [R21]
        end
    end

    // ------------------------------------------------------------
    // State decode outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            powerState <= PS_D0U;
            targetOnly <= 1'b1;
            configOnly <= 1'b0;
            fullFunction <= 1'b0;
        end else begin
            powerState <= state;
            targetOnly <= state == PS_D0U; // [R7]
            configOnly <= isLowD(state); // [R9] [R4]
            fullFunction <= state == PS_D0A; // [R8]
        end
    end

    // ------------------------------------------------------------
    // Link and wake status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            linkLowPower <= 1'b0;
            linkTxEnable <= 1'b1;
        end else begin
            linkLowPower <= lowPower;
            // No idle symbols in low power, no link integrity with wake off in D1, D2 or D3
            linkTxEnable <= !lowPower && !(isLowD(state) && !pmeEn_q); // [R2] [R5]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wakeArmed <= 1'b0;
            auxPowerPresent <= 1'b0;
        end else begin
            wakeArmed <= wakeCapable && (state != PS_D0U);
            auxPowerPresent <= auxSample_q; // [R6]
        end
    end

    // ------------------------------------------------------------
    // Configuration read port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgRdata <= 16'h0000;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgRead && cfgAllowed;
            if (!(cfgRead && cfgAllowed)) begin
                cfgRdata <= 16'h0000;
            end else if (cfgAddr == PMC_OFFSET) begin
                cfgRdata <= PMC_BASE_VALUE | (16'(auxSample_q) << PMC_AUX_WAKE_BIT); // [R10]
            end else if (cfgAddr == POWER_CTRL_STATUS_REGISTER_OFFSET) begin
                cfgRdata <= (16'(dField_q) << PS_LSB) | (16'(pmeEn_q) << PME_EN_BIT)
                    | (16'(pmeStatus_q) << PME_STATUS_BIT);
            end else begin
                cfgRdata <= 16'h0000;
            end
        end
    end

endmodule

// *** nic_pm_pkg.sv ***
/*
 * Constants shared by the power-state and reset controller: configuration
 * offsets, field positions, reset values and the D-state type.
 * Assumes the configuration access port addresses 16-bit registers by byte offset.
 */
// Overview of operation
// R1 - In D2 with link down, a low-power mode only watches for link becoming valid.
// R2 - In that low-power mode, idle symbols and link pulses stop.
// R3 - Low-power entry only when the driver power register bit allows it.
// R4 - D3 behaves exactly like D2; the code initializes on the RST# trailing edge in D3.
// R5 - Wake disabled in non-D0: no wake capability and no link integrity.
// R6 - On auxiliary power, full wake capability stays while PCI power is absent.
// R7 - Uninitialized D0 gives target access only and ignores the link.
// R8 - Active D0: full function, wake armed on any link change.
// R9 - D1: config access only; wake on packet or link loss, or link valid.
// R10 - Aux sense sampled while either reset is active; shown in capability register.
// R11 - Power-on reset low initializes all logic.
// R12 - Isolate active: ignore PCI inputs, float PCI outputs except the wake pin.
// R13 - With wake enabled, PCI reset keeps power registers and wake context.
// R14 - PCI reset active: ignore other PCI inputs and float PCI outputs.
// R15 - With aux power present, PCI reset affects nothing.
// R16 - In D0, D1, D2, initialization follows the PCI reset level.
// R17 - In D3, initialize on PCI reset trailing edge, keeping wake context.
// R18 - PCI reset trailing edge marks the B3 to B0 transition.
// R19 - Isolate trailing edge also initializes config, MAC config and memory state.
// R20 - After reset start in uninitialized D0; base address write makes it active.
// R21 - Wake events signalled only while the wake-enable bit is set.
// R22 - Reset and isolate inputs are synchronized before level or edge use.
// R23 - Current D-state comes from the software-written power state field.
package nic_pm_pkg;

    localparam logic [7:0] PMC_OFFSET = 8'hDE;
    localparam logic [7:0] POWER_CTRL_STATUS_REGISTER_OFFSET = 8'hE0;

    localparam logic [15:0] PMC_BASE_VALUE = 16'h0002;
    localparam int PMC_AUX_WAKE_BIT = 15;

    localparam int PS_LSB = 0;
    localparam int PME_EN_BIT = 8;
    localparam int PME_STATUS_BIT = 15;
    localparam logic [15:0] POWER_CTRL_STATUS_REGISTER_RESET = 16'h0000;

    localparam logic [1:0] DSTATE_D0 = 2'h0;
    localparam logic [1:0] DSTATE_D1 = 2'h1;
    localparam logic [1:0] DSTATE_D2 = 2'h2;
    localparam logic [1:0] DSTATE_D3 = 2'h3;

    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        PS_D0U,
        PS_D0A,
        PS_D1,
        PS_D2,
        PS_D3
    } pwr_state_t;

endpackage

// *** pin_sync.sv ***
/*
 * Multi-bit two-flop synchronizer for asynchronous pins.
 * Assumes each bit is an independent level; no bus coherency across bits.
 */
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// *** nic_pm_props.sv ***
/* Concurrent checks on the ports of the power and reset controller.
   Bound into nic_power_state_reset_ctrl; the reset and isolate pins are async. */
`timescale 1ns/10ps
module nic_pm_props
    import nic_pm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic powerOnResetIn_n,
    input wire logic busIsolateIn_n,
    input wire logic pciResetIn_n,
    input wire logic [7:0] cfgAddr,
    input wire logic [15:0] cfgRdata,
    input wire logic cfgRdValid,
    input wire logic internalInit,
    input wire logic busPowerUp,
    input wire logic pciOe_n,
    input wire logic pmeOut,
    input wire logic pmeOe_n,
    input wire logic auxPowerPresent,
    input wire logic [2:0] powerState,
    input wire logic linkLowPower,
    input wire logic linkTxEnable
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----
    // Pin timing: two sync flops plus the output register
    // ----
    pme_idle_a: assert property (pmeOut == 1'b0)
        else $error("wake pin data not low");
    por_init_a: assert property ((!powerOnResetIn_n) [*3] |=> internalInit && pciOe_n)
        else $error("power-on reset did not initialize");
    rst_level_a: assert property ((!pciResetIn_n && busIsolateIn_n) [*3] ##0
        (powerState != PS_D3 && !auxPowerPresent) |=> internalInit && pciOe_n)
        else $error("reset level did not hold init");
    iso_float_a: assert property ((!busIsolateIn_n) [*3] |=> pciOe_n)
        else $error("bus outputs driven while isolated");
    b3_b0_a: assert property ($rose(pciResetIn_n) && busIsolateIn_n && !auxPowerPresent
        |-> ##3 busPowerUp)
        else $error("no bus power-up pulse");
    iso_no_bpu_a: assert property ($fell(busIsolateIn_n) && !pciResetIn_n && !$past(pciResetIn_n)
        |-> ##3 !busPowerUp)
        else $error("isolation entry taken as bus power-up");
    bpu_pulse_a: assert property (busPowerUp |=> !busPowerUp)
        else $error("bus power-up pulse too long");
    d3_edge_a: assert property ($rose(pciResetIn_n) && busIsolateIn_n && powerState == PS_D3
        && !auxPowerPresent |-> ##3 internalInit)
        else $error("no init on reset trailing edge");
    lp_txoff_a: assert property (linkLowPower |-> !linkTxEnable)
        else $error("link pulses sent in low power");
    lp_state_a: assert property (linkLowPower |-> powerState == PS_D2 || powerState == PS_D3)
        else $error("low power outside D2 or D3");
    pmc_read_a: assert property (cfgRdValid && $past(cfgAddr) == PMC_OFFSET
        |-> cfgRdata == (PMC_BASE_VALUE | {auxPowerPresent, 15'h0000}))
        else $error("capability register value wrong");

    cover property (busPowerUp);
    cover property (linkLowPower);
    cover property (!pmeOe_n);
endmodule

bind nic_power_state_reset_ctrl nic_pm_props props (.clk(clk), .rst(rst),
    .powerOnResetIn_n(powerOnResetIn_n), .busIsolateIn_n(busIsolateIn_n), .pciResetIn_n(pciResetIn_n),
    .cfgAddr(cfgAddr), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid), .internalInit(internalInit),
    .busPowerUp(busPowerUp), .pciOe_n(pciOe_n), .pmeOut(pmeOut), .pmeOe_n(pmeOe_n),
    .auxPowerPresent(auxPowerPresent), .powerState(powerState), .linkLowPower(linkLowPower),
    .linkTxEnable(linkTxEnable));

// *** pci_host_model.sv ***
/* Host side of the bus: power good (isolate) and RST# sequencing.
   Assumes requests change on the falling edge; slow stretches the gaps. */
`timescale 1ns/10ps
module pci_host_model (
    input wire logic clk,
    input wire logic busOn,
    input wire logic warmRst,
    input wire logic slow,
    output logic busIsolateIn_n,
    output logic pciResetIn_n
);
    int gap;

    initial begin
        busIsolateIn_n = 1'b1;
        pciResetIn_n = 1'b1;
        forever begin
            @(negedge clk);
            gap = slow ? 9 : 4;
            if (!busOn && busIsolateIn_n) begin
                // Reset first, so RST# envelops the isolation
                pciResetIn_n = 1'b0;
                repeat (gap) @(negedge clk);
                busIsolateIn_n = 1'b0;
            end else if (busOn && !busIsolateIn_n) begin
                busIsolateIn_n = 1'b1;
                repeat (gap) @(negedge clk);
                pciResetIn_n = 1'b1;
            end else if (busOn) begin
                pciResetIn_n = !warmRst;
            end
        end
    end
endmodule

// *** tb.sv ***
/* Self-checking bench for the power and reset controller.
   Assumes the host model owns power good and RST#; the bench owns the rest. */
`timescale 1ns/10ps
module tb;
    import nic_pm_pkg::*;
    logic rst = 1'b1, porN = 1'b1, link = 1'b1, busOn = 1'b1;
    logic aux = 1'b0, allow = 1'b0, bar = 1'b0, cw = 1'b0, cr = 1'b0, warm = 1'b0, slow = 1'b0, pkt = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic clk, rdv, init, bpu, pciOe_n, pme, pmeOe_n, auxP, tOnly, cOnly, full, lp, tx, wake, isoN, rstN;
    logic [15:0] rdat;
    logic [2:0] ps;
    int num_errors = 0;
    int samples_checked = 0;
    int ds = 0, act = 0, pe = 0, nInit = 0, nBpu = 0, i0 = 0, b0 = 0;

    nic_power_state_reset_ctrl dut (
        .clk(clk), .rst(rst), .powerOnResetIn_n(porN), .busIsolateIn_n(isoN), .pciResetIn_n(rstN),
        .auxPowerSensePin(aux), .linkValidPin(link), .interestingPacket(pkt), .lowPowerAllow(allow),
        .barWrite(bar), .cfgWrite(cw), .cfgRead(cr), .cfgAddr(ad), .cfgWdata(wd), .cfgRdata(rdat),
        .cfgRdValid(rdv), .internalInit(init), .busPowerUp(bpu), .pciOe_n(pciOe_n), .pmeOut(pme),
        .pmeOe_n(pmeOe_n), .auxPowerPresent(auxP), .powerState(ps), .targetOnly(tOnly),
        .configOnly(cOnly), .fullFunction(full), .linkLowPower(lp), .linkTxEnable(tx), .wakeArmed(wake)
    );
    pci_host_model host (.clk(clk), .busOn(busOn), .warmRst(warm), .slow(slow), .busIsolateIn_n(isoN),
        .pciResetIn_n(rstN));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (init === 1'b1) nInit++;
        if (bpu === 1'b1) nBpu++;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Read data is registered: valid one cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        cr = 1'b1;
        ad = a;
        @(negedge clk);
        chk(16'(rdv), 16'h0001);
        chk(rdat, e);
        cr = 1'b0;
    endtask

    // Always writes the status bit so stale wake status is cleared
    task automatic wr(input int d, input int p);
        ds = d;
        pe = p;
        @(negedge clk);
        cw = 1'b1;
        ad = POWER_CTRL_STATUS_REGISTER_OFFSET;
        wd = 16'h8000 | 16'(p << 8) | 16'(d);
        @(negedge clk);
        cw = 1'b0;
        cyc(2);
    endtask

    task automatic st();
        chk(16'(ps), 16'(ds == 0 ? act : ds + 1));
    endtask

    // ----
    // Scenarios
    // ----
    initial begin
        void'($urandom(21227));
        cyc(4);
        rst = 1'b0;
        cyc(6);
        chk(16'({ps, tOnly, pciOe_n, init}), 16'h0004);
        rd(PMC_OFFSET, 16'h0002);
        rd(8'h40, 16'h0000);
        bar = 1'b1;
        cyc(1);
        bar = 1'b0;
        act = 1;
        cyc(2);
        st();
        for (int d = 0; d < 3; d++) begin
            wr(d, $urandom % 2);
            st();
            chk(16'({tOnly, cOnly, full, wake}), 16'({1'b0, d > 0, d == 0, pe == 1}));
        end
        wr(1, 1);
        pkt = 1'b1;
        cyc(1);
        pkt = 1'b0;
        cyc(3);
        chk(16'({pme, pmeOe_n}), 16'h0000);
        wr(1, 1);
        chk(16'(pmeOe_n), 16'h0001);
        link = 1'b0;
        cyc(6);
        chk(16'({pme, pmeOe_n}), 16'h0000);
        rd(POWER_CTRL_STATUS_REGISTER_OFFSET, 16'h8101);
        wr(1, 1);
        chk(16'(pmeOe_n), 16'h0001);
        warm = 1'b1;
        cyc(6);
        chk(16'({init, pciOe_n}), 16'h0003);
        warm = 1'b0;
        cyc(6);
        rd(POWER_CTRL_STATUS_REGISTER_OFFSET, 16'h0101);
        for (int d = 2; d < 4; d++) begin
            wr(d, 1);
            for (int a = 1; a >= 0; a--) begin
                allow = a[0];
                cyc(5);
                chk(16'({lp, tx, wake}), a ? 16'h0005 : 16'h0003);
            end
        end
        wr(3, 0);
        chk(16'({tx, wake}), 16'h0000);
        wr(3, 1);
        i0 = nInit;
        b0 = nBpu;
        warm = 1'b1;
        cyc(6);
        chk(16'({pciOe_n, 1'(nInit - i0)}), 16'h0002);
        warm = 1'b0;
        cyc(6);
        chk(16'({4'(nInit - i0), 4'(nBpu - b0)}), 16'h0011);
        rd(POWER_CTRL_STATUS_REGISTER_OFFSET, 16'h0103);
        slow = 1'($urandom % 2);
        busOn = 1'b0;
        cyc(30);
        chk(16'(pciOe_n), 16'h0001);
        busOn = 1'b1;
        cyc(30);
        ds = 0;
        act = 0;
        rd(POWER_CTRL_STATUS_REGISTER_OFFSET, 16'h0000);
        st();
        chk(16'(nBpu - b0), 16'h0002);
        aux = 1'b1;
        porN = 1'b0;
        cyc(4);
        chk(16'({init, pciOe_n}), 16'h0003);
        porN = 1'b1;
        cyc(6);
        rd(PMC_OFFSET, 16'h8002);
        chk(16'(auxP), 16'h0001);
        wr(1, 1);
        i0 = nInit;
        warm = 1'b1;
        cyc(6);
        warm = 1'b0;
        cyc(6);
        chk(16'({1'(nInit - i0), wake}), 16'h0001);
        aux = 1'b0;
        porN = 1'b0;
        cyc(4);
        porN = 1'b1;
        cyc(6);
        rd(POWER_CTRL_STATUS_REGISTER_OFFSET, 16'h0000);
        rd(PMC_OFFSET, 16'h0002);
        tally_and_finish();
    end

    // Tests need well under 1000 cycles; this is 10000
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
endmodule
